// >>> verilog/pms_map.svh
// Purpose: Mode codes, field positions, reset values and timing counts of the power mode sequencer.
// Assumes: 40 MHz reference clock.
// Notes: Definitions only.
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH
`define PMS_MODE_NORMAL 2'h1
`define PMS_MODE_REDUCED 2'h0
`define PMS_MODE_LOWPWR 2'h2
`define PMS_MODE_SLEEP 2'h3
`define PMS_CLK_HZ 40000000
`define PMS_LP_UNIT_MS 20
`define PMS_LP_UNIT_CYC ((`PMS_CLK_HZ / 1000) * `PMS_LP_UNIT_MS)
`define PMS_DEBOUNCE_CYC 4
`define PMS_SETTLE_CYC 16
`define PMS_THR_CODE_LSB 0
`define PMS_THR_CODE_MSB 2
`define PMS_PERIOD_LSB 3
`define PMS_PERIOD_MSB 7
`define PMS_LP_THR_RST 8'h07
`define PMS_RETAINED_RST 8'h00
`define PMS_RESET_COMPLETE_FLAG_BIT 15
`endif

// >>> verilog/pms_pkg.sv
// Purpose: Types shared by the power mode sequencer.
// Assumes: Nothing beyond the map header.
// Notes: Types only.
package pms_pkg;
    typedef enum logic [2:0] {
        PMS_ST_IDLE,
        PMS_ST_RESET,
        PMS_ST_NORMAL,
        PMS_ST_REDUCED,
        PMS_ST_LOWPWR,
        PMS_ST_LP_DONE,
        PMS_ST_SLEEP
    } pms_state_t;

    typedef struct packed {
        logic i2c_en;
        logic spi_en;
        logic hs_en;
        logic regs_valid;
        logic mav_run;
        logic circuits_on;
    } pms_ctl_t;
endpackage : pms_pkg

// >>> verilog/pms_sequencer.sv
// Purpose: Power mode sequencer: mode pins, resets, alert pins and reset-complete flag.
// Assumes: Inputs synchronous to i_ref_clk; arithmetic of the measurement lives outside.
// Notes: Threshold crossings arrive as one pulse per phase and crossing.
//
// Operation
// - Mode pins select normal 01, reduced 00, low power 10, sleep 11.
// - Sleep mode disables the I2C, SPI and high speed capture ports.
// - Hardware reset in normal mode defaults all registers, enables I2C (for its first cycle only if SPI is selected and locked), processor idle.
// - Software reset defaults registers but keeps retained setup and threshold.
// - Software reset keeps the locked serial port choice.
// - Outside normal mode general registers are unavailable; retained pair kept.
// - Reduced mode runs the mean absolute value computation continuously.
// - Reduced mode keeps the active serial port enabled for result reads.
// - Low power mode compares currents to threshold and asserts one alert.
// - Window is 20 ms times period plus one; counts decide which alert.
// - Low power mode offers no serial port.
// - Sleep mode shuts circuits down; no measurement takes place.
// - Normal to reduced starts the computation at once, results readable.
// - Low power to reduced pulls event alert low when computation begins.
// - Sleep to reduced pulls event alert low when computation begins.
// - Entering normal pulls event alert low and sets reset complete.
// - Reset complete is unmaskable, cleared by writing its bit one or when a reset begins.
`timescale 1ns/1ps
`include "pms_map.svh"
`default_nettype none
module pms_sequencer #(
    parameter int LP_UNIT_CYC = `PMS_LP_UNIT_CYC,
    parameter int DEBOUNCE_CYC = `PMS_DEBOUNCE_CYC,
    parameter int SETTLE_CYC = `PMS_SETTLE_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_mode_select_high_pin,
    input wire logic i_mode_select_low_pin,
    input wire logic i_hw_reset_n,
    input wire logic i_sw_reset,
    input wire logic i_spi_selected,
    input wire logic i_port_locked,
    input wire logic i_hs_port_enable,
    input wire logic i_thr_wr,
    input wire logic [7:0] i_thr_wdata,
    input wire logic i_retained_wr,
    input wire logic [7:0] i_retained_wdata,
    input wire logic i_status_b_wr,
    input wire logic [15:0] i_status_b_wdata,
    input wire logic [2:0] i_phase_over,
    output logic o_idle_alert_n,
    output logic o_event_alert_n,
    output logic o_reset_complete_flag,
    output logic [7:0] o_low_power_threshold_reg,
    output logic [7:0] o_retained_setup_reg,
    output pms_pkg::pms_ctl_t o_ctl,
    output logic o_defaults_load
);
    // ----------------------------------------------------------------
    // Mode pin debounce
    // ----------------------------------------------------------------
    logic [1:0] pins_q, stable_q;
    logic [3:0] db_cnt_q;
    wire logic [1:0] pins_now = {i_mode_select_high_pin, i_mode_select_low_pin};
    wire logic db_done = (db_cnt_q == 4'(DEBOUNCE_CYC - 1));
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pins_q <= `PMS_MODE_SLEEP;
            stable_q <= `PMS_MODE_SLEEP;
            db_cnt_q <= 4'h0;
        end else if (i_clk_en) begin
            pins_q <= pins_now;
            if (pins_now != pins_q) begin
                db_cnt_q <= 4'h0;
            end else if (!db_done) begin
                db_cnt_q <= db_cnt_q + 4'h1;
            end else begin
                stable_q <= pins_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // State machine
    // ----------------------------------------------------------------
    pms_pkg::pms_state_t st_q, st_d;
    logic [4:0] settle_q;
    logic [31:0] win_q;
    logic [4:0] slot_q;
    logic [5:0] cnt_q [3];
    wire logic [4:0] lp_period = o_low_power_threshold_reg[`PMS_PERIOD_MSB:`PMS_PERIOD_LSB];
    wire logic [5:0] lp_limit = {1'b0, lp_period} + 6'h01;
    wire logic slot_end = (win_q == 32'(LP_UNIT_CYC - 1));
    wire logic win_end = slot_end && (slot_q == lp_period);
    wire logic any_over = (cnt_q[0] >= lp_limit) || (cnt_q[1] >= lp_limit)
        || (cnt_q[2] >= lp_limit);
    wire logic settle_done = (settle_q == 5'(SETTLE_CYC - 1));
    wire logic hw_rst = !i_hw_reset_n && (st_q == pms_pkg::PMS_ST_NORMAL);
    wire logic sw_rst = i_sw_reset && (st_q == pms_pkg::PMS_ST_NORMAL);
    wire logic mode_chg = (st_q != pms_pkg::PMS_ST_RESET) && (st_q != pms_pkg::PMS_ST_IDLE);
    wire logic rc_clear = i_status_b_wr && i_status_b_wdata[`PMS_RESET_COMPLETE_FLAG_BIT];
    always_comb begin
        st_d = st_q;
        case (st_q)
            pms_pkg::PMS_ST_RESET: begin
                if (settle_done) begin
                    st_d = pms_pkg::PMS_ST_NORMAL;
                end
            end
            default: begin
                if (hw_rst || sw_rst) begin
                    st_d = pms_pkg::PMS_ST_RESET;
                end else if (mode_chg || st_q == pms_pkg::PMS_ST_IDLE) begin
                    case (stable_q)
                        `PMS_MODE_NORMAL: begin
                            if (st_q != pms_pkg::PMS_ST_NORMAL) begin
                                st_d = pms_pkg::PMS_ST_RESET;
                            end
                        end
                        `PMS_MODE_REDUCED: st_d = pms_pkg::PMS_ST_REDUCED;
                        `PMS_MODE_LOWPWR: begin
                            if (st_q != pms_pkg::PMS_ST_LP_DONE) begin
                                st_d = pms_pkg::PMS_ST_LOWPWR;
                            end
                        end
                        default: st_d = pms_pkg::PMS_ST_SLEEP;
                    endcase
                    if (st_q == pms_pkg::PMS_ST_LOWPWR && stable_q == `PMS_MODE_LOWPWR
                            && win_end) begin
                        st_d = pms_pkg::PMS_ST_LP_DONE;
                    end
                end
            end
        endcase
    end

    wire logic enter_reset = (st_d == pms_pkg::PMS_ST_RESET) && (st_q != pms_pkg::PMS_ST_RESET);
    wire logic enter_lp = (st_d == pms_pkg::PMS_ST_LOWPWR) && (st_q != pms_pkg::PMS_ST_LOWPWR);
    wire logic enter_red = (st_d == pms_pkg::PMS_ST_REDUCED) && (st_q != pms_pkg::PMS_ST_REDUCED);
    wire logic red_from_low = enter_red && (st_q == pms_pkg::PMS_ST_LOWPWR
        || st_q == pms_pkg::PMS_ST_LP_DONE || st_q == pms_pkg::PMS_ST_SLEEP);
    wire logic lp_fire = (st_d == pms_pkg::PMS_ST_LP_DONE) && (st_q == pms_pkg::PMS_ST_LOWPWR);
    wire logic in_lp = (st_q == pms_pkg::PMS_ST_LOWPWR);
    // A state change releases a held alert, except the event alert while the reset-complete flag is set, so a later entry can pull it low afresh.
    wire logic leave_alert = (st_d != st_q);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st_q <= pms_pkg::PMS_ST_IDLE;
            settle_q <= 5'h00;
        end else if (i_clk_en) begin
            st_q <= st_d;
            settle_q <= enter_reset ? 5'h00 : settle_q + 5'h01;
        end
    end

    // ----------------------------------------------------------------
    // Low power window and per phase counters
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || !in_lp) begin
            win_q <= 32'h0;
            slot_q <= 5'h00;
            for (int p = 0; p < 3; p++) begin
                cnt_q[p] <= 6'h00;
            end
        end else if (i_clk_en) begin
            win_q <= slot_end ? 32'h0 : win_q + 32'h1;
            if (slot_end) begin
                slot_q <= slot_q + 5'h01;
            end
            for (int p = 0; p < 3; p++) begin
                if (i_phase_over[p] && cnt_q[p] != 6'h3F) begin
                    cnt_q[p] <= cnt_q[p] + 6'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Retained registers, alerts, flag and control outputs
    // ----------------------------------------------------------------
    wire logic normal = (st_q == pms_pkg::PMS_ST_NORMAL);
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_low_power_threshold_reg <= `PMS_LP_THR_RST;
            o_retained_setup_reg <= `PMS_RETAINED_RST;
            o_idle_alert_n <= 1'b1;
            o_event_alert_n <= 1'b1;
            o_reset_complete_flag <= 1'b0;
            o_ctl <= '0;
            o_defaults_load <= 1'b0;
        end else if (i_clk_en) begin
            // Mode returns and software resets keep the retained pair.
            if (enter_reset && hw_rst) begin
                o_low_power_threshold_reg <= `PMS_LP_THR_RST;
                o_retained_setup_reg <= `PMS_RETAINED_RST;
            end else if (normal) begin
                if (i_thr_wr) begin
                    o_low_power_threshold_reg <= i_thr_wdata;
                end
                if (i_retained_wr) begin
                    o_retained_setup_reg <= i_retained_wdata;
                end
            end
            o_defaults_load <= enter_reset;
            // Completion wins over a clear arriving in the same cycle.
            if (st_q == pms_pkg::PMS_ST_RESET && settle_done) begin
                o_reset_complete_flag <= 1'b1;
                o_event_alert_n <= 1'b0;
            end else if (enter_reset) begin
                o_reset_complete_flag <= 1'b0;
                o_event_alert_n <= 1'b1;
            end else if (red_from_low || (lp_fire && any_over)) begin
                o_event_alert_n <= 1'b0;
            end else if (o_reset_complete_flag && rc_clear) begin
                o_reset_complete_flag <= 1'b0;
                o_event_alert_n <= 1'b1;
            end else if (leave_alert && !o_reset_complete_flag) begin
                o_event_alert_n <= 1'b1;
            end
            if (lp_fire && !any_over) begin
                o_idle_alert_n <= 1'b0;
            end else if (leave_alert || enter_red) begin
                o_idle_alert_n <= 1'b1;
            end
            o_ctl.regs_valid <= (st_d == pms_pkg::PMS_ST_NORMAL);
            // The locked port survives a software reset; hardware reset forces I2C on in its first cycle only; SPI stays off for the whole reset.
            o_ctl.spi_en <= (st_d == pms_pkg::PMS_ST_NORMAL || st_d == pms_pkg::PMS_ST_REDUCED)
                && i_spi_selected && (i_port_locked || !enter_reset) && !hw_rst;
            o_ctl.i2c_en <= (st_d == pms_pkg::PMS_ST_NORMAL || st_d == pms_pkg::PMS_ST_REDUCED
                || st_d == pms_pkg::PMS_ST_RESET)
                && !(i_spi_selected && i_port_locked && !hw_rst);
            o_ctl.hs_en <= (st_d == pms_pkg::PMS_ST_NORMAL) && i_hs_port_enable;
            o_ctl.mav_run <= (st_d == pms_pkg::PMS_ST_REDUCED)
                || (st_d == pms_pkg::PMS_ST_NORMAL);
            o_ctl.circuits_on <= (st_d != pms_pkg::PMS_ST_SLEEP)
                && (st_d != pms_pkg::PMS_ST_IDLE);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sleep_ports_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_clk_en && st_d == pms_pkg::PMS_ST_SLEEP) |=> !o_ctl.i2c_en && !o_ctl.spi_en
        && !o_ctl.hs_en) else $error("serial port live in sleep");
    sleep_dark_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_clk_en && st_d == pms_pkg::PMS_ST_SLEEP) |=> !o_ctl.circuits_on && !o_ctl.mav_run)
        else $error("circuits on in sleep");
    lp_no_port_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_clk_en && st_d == pms_pkg::PMS_ST_LOWPWR) |=> !o_ctl.i2c_en && !o_ctl.spi_en)
        else $error("port live in low power");
    done_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_clk_en && st_q == pms_pkg::PMS_ST_RESET && settle_done) |=>
        o_reset_complete_flag && !o_event_alert_n) else $error("reset done not flagged");
    flag_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (st_q == pms_pkg::PMS_ST_RESET && !settle_done) |-> ##1 !o_reset_complete_flag)
        else $error("flag set during transition");
    flag_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ($fell(o_reset_complete_flag) && $past(st_q) != pms_pkg::PMS_ST_RESET
        && !$past(enter_reset)) |-> $past(rc_clear)) else $error("flag lost");
    sw_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_clk_en && sw_rst && i_hw_reset_n) |=> $stable(o_low_power_threshold_reg)
        && $stable(o_retained_setup_reg)) else $error("retained lost on soft reset");
    hw_dflt_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_clk_en && hw_rst) |=> o_low_power_threshold_reg == `PMS_LP_THR_RST)
        else $error("threshold not defaulted");
    lp_alert_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_clk_en && lp_fire) |=> (o_idle_alert_n != o_event_alert_n))
        else $error("low power result not signalled");
    red_mav_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_clk_en && enter_red) |=> o_ctl.mav_run) else $error("mav not started");
    cv_normal: cover property (@(posedge i_ref_clk) o_reset_complete_flag ##[1:20] rc_clear);
    cv_lpdone: cover property (@(posedge i_ref_clk) lp_fire && any_over);
    cv_idle: cover property (@(posedge i_ref_clk) lp_fire && !any_over);
    cv_sleep_red: cover property (@(posedge i_ref_clk) red_from_low);
endmodule : pms_sequencer
`default_nettype wire

// >>> tb/pms_host_model.sv
// Purpose: Behavioural model of the metering controller facing the power mode sequencer.
// Assumes: One clock; mode changes are requested by the bench through i_mode_req.
// Notes: Acknowledges the reset-complete flag after a short, deliberately slow delay.
`timescale 1ns/1ps
`include "pms_map.svh"
`default_nettype none
module pms_host_model (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_mode_req,
    input wire logic i_event_alert_n,
    input wire logic i_reset_complete_flag,
    output logic o_mode_select_high_pin,
    output logic o_mode_select_low_pin,
    output logic o_hs_port_enable,
    output logic o_status_b_wr,
    output logic [15:0] o_status_b_wdata
);
    logic [1:0] pins_q;
    logic [2:0] ack_cnt_q;
    logic leave_normal;

    assign o_mode_select_high_pin = pins_q[1];
    assign o_mode_select_low_pin = pins_q[0];
    assign o_status_b_wdata = 16'h8000;
    assign leave_normal = (pins_q == `PMS_MODE_NORMAL) && o_hs_port_enable;

    // --------------------------------------------------------------------------
    // Mode pins and acknowledge
    // --------------------------------------------------------------------------
    // Power-up leaves the pins high, so the device starts out in sleep.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pins_q <= `PMS_MODE_SLEEP;
            o_hs_port_enable <= 1'b0;
            o_status_b_wr <= 1'b0;
            ack_cnt_q <= 3'h0;
        end else begin
            o_status_b_wr <= 1'b0;
            if (i_mode_req != pins_q) begin
                if (leave_normal) begin
                    // The idle cycle before the pins move stands for the run stop and mask clears.
                    o_hs_port_enable <= 1'b0;
                end else begin
                    pins_q <= i_mode_req;
                    o_hs_port_enable <= (i_mode_req == `PMS_MODE_NORMAL);
                end
            end
            if (i_reset_complete_flag && !i_event_alert_n && !o_status_b_wr) begin
                ack_cnt_q <= ack_cnt_q + 3'h1;
                if (ack_cnt_q == 3'h3) begin
                    o_status_b_wr <= 1'b1;
                    ack_cnt_q <= 3'h0;
                end
            end
        end
    end
endmodule : pms_host_model
`default_nettype wire

// >>> tb/pms_sequencer_tb.sv
// Purpose: Self-checking bench of the power mode sequencer.
// Assumes: Short low-power unit of 10 cycles; host model drives the mode pins.
// Notes: Expected events are queued by the driver and checked by the monitor.
`timescale 1ns/1ps
`include "pms_map.svh"
`default_nettype none
module pms_sequencer_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic dload_seen = 1'b0;
    logic hw_n = 1'b1;
    logic sw = 1'b0;
    logic spi_sel = 1'b0;
    logic lock = 1'b0;
    logic thr_wr = 1'b0;
    logic ret_wr = 1'b0;
    logic [7:0] thr_d = 8'h00;
    logic [7:0] ret_d = 8'h00;
    logic [2:0] ph = 3'h0;
    logic [1:0] mode_req = `PMS_MODE_SLEEP;
    logic pm_hi, pm_lo, hs_en, st_wr, idle_n, ev_n, flag, dload;
    logic [15:0] st_d;
    logic [7:0] thr_q, ret_q;
    pms_pkg::pms_ctl_t ctl;
    logic flag_p = 1'b0;
    logic idle_p = 1'b1;
    logic ev_p = 1'b1;
    int num_errors = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'hE985;
    logic [16:0] q_done[$];
    logic [1:0] q_alert[$];

    always #12.5 clk = ~clk;

    pms_sequencer #(.LP_UNIT_CYC(10)) u_pms_sequencer (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_clk_en(clk_en), .i_mode_select_high_pin(pm_hi), .i_mode_select_low_pin(pm_lo),
        .i_hw_reset_n(hw_n), .i_sw_reset(sw), .i_spi_selected(spi_sel), .i_port_locked(lock),
        .i_hs_port_enable(hs_en), .i_thr_wr(thr_wr), .i_thr_wdata(thr_d),
        .i_retained_wr(ret_wr), .i_retained_wdata(ret_d), .i_status_b_wr(st_wr),
        .i_status_b_wdata(st_d), .i_phase_over(ph), .o_idle_alert_n(idle_n),
        .o_event_alert_n(ev_n), .o_reset_complete_flag(flag),
        .o_low_power_threshold_reg(thr_q), .o_retained_setup_reg(ret_q), .o_ctl(ctl),
        .o_defaults_load(dload));

    pms_host_model u_pms_host_model (.i_ref_clk(clk), .i_rst_n(rst_n), .i_mode_req(mode_req),
        .i_event_alert_n(ev_n), .i_reset_complete_flag(flag), .o_mode_select_high_pin(pm_hi),
        .o_mode_select_low_pin(pm_lo), .o_hs_port_enable(hs_en), .o_status_b_wr(st_wr),
        .o_status_b_wdata(st_d));

    // --------------------------------------------------------------------------
    // Compare and report
    // --------------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction : xs
    task automatic end_of_test;
        if (num_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic report(input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t exp=%0h got=%0h", $time, e, g);
        end
    endtask : report
    task automatic cmp_done(input logic [16:0] e, input logic [16:0] g);
        report({15'h0, e}, {15'h0, g});
    endtask : cmp_done
    task automatic cmp_alert(input logic [1:0] e, input logic [1:0] g);
        report({30'h0, e}, {30'h0, g});
    endtask : cmp_alert
    task automatic cmp_load(input logic e, input logic g);
        report({31'h0, e}, {31'h0, g});
    endtask : cmp_load
    task automatic cmp_ctl(input logic [5:0] e, input logic [5:0] m, input logic [5:0] g);
        report({26'h0, e}, {26'h0, g & m});
    endtask : cmp_ctl

    // --------------------------------------------------------------------------
    // Monitor
    // --------------------------------------------------------------------------
    // Events are seen from the values held before each edge, so no race with the design.
    always @(posedge clk) begin
        flag_p <= flag;
        idle_p <= idle_n;
        ev_p <= ev_n;
        if (rst_n && flag && !flag_p) begin
            if (q_done.size() == 0) report(32'h0, {15'h0, ev_n, thr_q, ret_q});
            else cmp_done(q_done.pop_front(), {ev_n, thr_q, ret_q});
            cmp_load(1'b1, dload_seen);
            dload_seen <= 1'b0;
        end
        if (dload) dload_seen <= 1'b1;
        if (rst_n && !flag && flag_p) cmp_alert(2'b11, {idle_n, ev_n});
        if (rst_n && ((idle_p && !idle_n) || (ev_p && !ev_n && !flag))) begin
            if (q_alert.size() == 0) report(32'h0, {30'h0, idle_p, ev_p});
            else cmp_alert(q_alert.pop_front(), {idle_p & !idle_n, ev_p & !ev_n});
        end
    end

    // --------------------------------------------------------------------------
    // Driver
    // --------------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic set_mode(input logic [1:0] m);
        @(posedge clk);
        mode_req <= m;
        cyc(12);
    endtask : set_mode
    task automatic wait_q;
        int n;
        n = 0;
        while ((q_done.size() + q_alert.size()) != 0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if ((q_done.size() + q_alert.size()) != 0) begin
            report(32'h0, q_done.size() + q_alert.size());
            end_of_test();
        end
        cyc(10);
    endtask : wait_q
    task automatic wr_regs(input logic [7:0] t, input logic [7:0] r);
        @(posedge clk);
        thr_wr <= 1'b1;
        thr_d <= t;
        ret_wr <= 1'b1;
        ret_d <= r;
        @(posedge clk);
        thr_wr <= 1'b0;
        ret_wr <= 1'b0;
    endtask : wr_regs
    task automatic pulse(input logic [2:0] p, input logic s);
        @(posedge clk);
        ph <= p;
        sw <= s;
        @(posedge clk);
        ph <= 3'h0;
        sw <= 1'b0;
    endtask : pulse

    initial begin
        cyc(3);
        rst_n <= 1'b1;
        cyc(8);
        q_done.push_back({1'b0, `PMS_LP_THR_RST, `PMS_RETAINED_RST});
        set_mode(`PMS_MODE_NORMAL);
        wait_q();
        wr_regs(8'h0B, 8'h5A);
        spi_sel <= 1'b1;
        lock <= 1'b1;
        q_done.push_back({1'b0, 8'h0B, 8'h5A});
        pulse(3'h0, 1'b1);
        wait_q();
        cmp_ctl(6'h1F, 6'h3F, ctl);
        spi_sel <= 1'b0;
        q_done.push_back({1'b0, `PMS_LP_THR_RST, `PMS_RETAINED_RST});
        @(posedge clk);
        hw_n <= 1'b0;
        cyc(4);
        hw_n <= 1'b1;
        wait_q();
        cmp_ctl(6'h2F, 6'h3F, ctl);
        // A frozen block must ignore a software reset; a taken one would raise the flag unasked.
        clk_en <= 1'b0;
        pulse(3'h0, 1'b1);
        @(posedge clk);
        clk_en <= 1'b1;
        wr_regs(8'h0B, 8'h5A);
        set_mode(`PMS_MODE_REDUCED);
        cmp_ctl(6'h23, 6'h3F, ctl);
        wr_regs(8'hFF, 8'hFF);
        @(posedge clk);
        mode_req <= `PMS_MODE_SLEEP;
        @(posedge clk);
        mode_req <= `PMS_MODE_REDUCED;
        cyc(12);
        cmp_ctl(6'h23, 6'h3F, ctl);
        q_alert.push_back(2'b10);
        set_mode(`PMS_MODE_LOWPWR);
        seed = xs(seed);
        pulse(seed[2:0], 1'b0);
        wait_q();
        cmp_ctl(6'h01, 6'h3F, ctl);
        q_alert.push_back(2'b01);
        set_mode(`PMS_MODE_REDUCED);
        wait_q();
        set_mode(`PMS_MODE_SLEEP);
        cmp_ctl(6'h00, 6'h3F, ctl);
        pulse(3'h0, 1'b1);
        q_alert.push_back(2'b01);
        set_mode(`PMS_MODE_REDUCED);
        wait_q();
        q_alert.push_back(2'b01);
        set_mode(`PMS_MODE_LOWPWR);
        seed = xs(seed);
        pulse(3'b001 << (seed % 3), 1'b0);
        pulse(3'b001 << (seed % 3), 1'b0);
        wait_q();
        q_done.push_back({1'b0, 8'h0B, 8'h5A});
        set_mode(`PMS_MODE_NORMAL);
        wait_q();
        end_of_test();
    end
endmodule : pms_sequencer_tb
`default_nettype wire
